// *** inc/sensor_pkg.sv ***
// Shared constants for the sensor clock bring-up host and device
package sensor_pkg;
  // ------------------------------------------------------------
  // Link widths
  // ------------------------------------------------------------
  localparam int AW = 9;
  localparam int DW = 16;
  localparam int NREG = 11;
  // ------------------------------------------------------------
  // Sensor register addresses
  // ------------------------------------------------------------
  localparam logic [8:0] A_COLOUR = 9'h002;
  localparam logic [8:0] A_PLL_RST = 9'h008;
  localparam logic [8:0] A_CGEN_RST = 9'h009;
  localparam logic [8:0] A_PLL_EN = 9'h010;
  localparam logic [8:0] A_PLL_CFG = 9'h011;
  localparam logic [8:0] A_LINK_CLK = 9'h014;
  localparam logic [8:0] A_LOCK_STAT = 9'h018;
  localparam logic [8:0] A_LOCK_A = 9'h01A;
  localparam logic [8:0] A_LOCK_B = 9'h01B;
  localparam logic [8:0] A_CLK_MGT = 9'h020;
  localparam logic [8:0] A_LOGIC_EN = 9'h022;
  localparam logic [8:0] A_SEQ = 9'h0C0;
  // Register file layout: entry i sits at REG_ADDR[i]
  localparam logic [NREG-1:0][8:0] REG_ADDR = {A_SEQ, A_LOGIC_EN, A_CLK_MGT,
    A_LOCK_B, A_LOCK_A, A_LINK_CLK, A_PLL_CFG, A_PLL_EN, A_CGEN_RST, A_PLL_RST, A_COLOUR};
  localparam int I_PLL_RST = 1;
  localparam int I_CGEN_RST = 2;
  localparam int I_PLL_EN = 3;
  localparam int I_LINK_CLK = 5;
  localparam int I_CLK_MGT = 8;
  localparam int I_LOGIC_EN = 9;
  localparam int I_SEQ = 10;
  // Entries reachable before any internal clock runs
  localparam logic [NREG-1:0] CM_SUBSET = 11'h1FF;
  localparam logic [NREG-1:0][15:0] REG_RESET = {16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000};
  // ------------------------------------------------------------
  // Field positions and values
  // ------------------------------------------------------------
  localparam int LOCK_BIT = 0;
  localparam int LOGIC_CLK_BIT = 1;
  localparam int LINK_CLK_BIT = 0;
  localparam int LOGIC_EN_BIT = 0;
  localparam int SEQ_EN_BIT = 0;
  localparam logic [15:0] PAR_SEL = 16'h0002;
  localparam logic [15:0] PLL_ON = 16'h0003;
  localparam logic [15:0] PLL_BYPASS = 16'h0007;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] CM1_S8_PLL = 16'h200C;
  localparam logic [15:0] CM1_S8_NOPLL = 16'h2008;
  localparam logic [15:0] CM1_S10_PLL = 16'h2004;
  localparam logic [15:0] CM1_S10_NOPLL = 16'h2000;
  localparam logic [15:0] CM1_PAR = 16'h200C;
  localparam logic [15:0] PLLC_S8 = 16'h210F;
  localparam logic [15:0] PLLC_S10 = 16'h2113;
  localparam logic [15:0] LDA_S8 = 16'h1180;
  localparam logic [15:0] LDA_S10 = 16'h2280;
  localparam logic [15:0] LDB_S8 = 16'hCCBC;
  localparam logic [15:0] LDB_S10 = 16'h3D2D;
  localparam logic [15:0] CM2_S8_PLL = 16'h200E;
  localparam logic [15:0] CM2_S8_NOPLL = 16'h200A;
  localparam logic [15:0] CM2_S10_PLL = 16'h2006;
  localparam logic [15:0] CM2_S10_NOPLL = 16'h2002;
  localparam logic [15:0] CM2_PAR = 16'h200E;
  // ------------------------------------------------------------
  // Modes, states, timing, host registers
  // ------------------------------------------------------------
  typedef enum logic [2:0] {M_S8_PLL, M_S8_NOPLL, M_S10_PLL, M_S10_NOPLL, M_PAR10} out_mode_t;
  typedef enum logic [2:0] {ST_LP_STBY, ST_STBY1, ST_STBY2, ST_IDLE, ST_RUN} dev_state_t;
  localparam int CLK_MHZ = 100;
  localparam int T_RST_WAIT_US = 10;
  localparam int RST_WAIT_CYC = T_RST_WAIT_US * CLK_MHZ;
  localparam int CLK_SETTLE_CYC = 16;
  localparam int LOCK_CYC = 64;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam int C_START = 0;
  localparam int C_MODE_LSB = 1;
  localparam int C_COLOUR = 4;
  localparam int S_DONE = 4;
  localparam int S_ERR = 5;
  localparam int S_BUSY = 6;
endpackage : sensor_pkg

// *** inc/sensor_link_if.sv ***
// Register-upload link between bring-up host and sensor clock logic
`timescale 1ns/1ps
interface sensor_link_if;
  logic clk_run;
  logic chip_rst_n;
  logic req;
  logic we;
  logic [8:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic err;
  logic [15:0] rdata;
  modport host (output clk_run, chip_rst_n, req, we, addr, wdata, input ack, err, rdata);
  modport sensor (input clk_run, chip_rst_n, req, we, addr, wdata, output ack, err, rdata);
endinterface : sensor_link_if

// *** src/sensor_clock_dev.sv ***
// Sensor-side clock management registers and power state tracking
`timescale 1ns/1ps
module sensor_clock_dev #(
  parameter int LOCK_CYC = sensor_pkg::LOCK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  sensor_link_if.sensor link,
  output logic [2:0] dev_state,
  output logic pll_locked,
  output logic logic_clk_on,
  output logic blocks_on,
  output logic grabbing,
  output logic [3:0] shutter_cfg,
  output logic [1:0] sensor_clk_src
);
  typedef struct packed {
    logic [sensor_pkg::NREG-1:0][15:0] regs;
    logic pll_run;
    logic [15:0] lock_cnt;
    logic locked;
    logic ack;
    logic err;
    logic [15:0] rdata;
    sensor_pkg::dev_state_t st;
    logic lclk;
    logic blk;
    logic grab;
    logic [3:0] shut;
    logic [1:0] src;
  } dst_t;

  dst_t q;
  dst_t n;
  logic bypass;
  logic src_on;
  logic hit;
  logic ok;
  int hi;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    hit = 1'b0;
    ok = 1'b0;
    hi = 0;
    n.ack = 1'b0;
    n.err = 1'b0;
    bypass = q.regs[sensor_pkg::I_PLL_EN] == sensor_pkg::PLL_BYPASS;
    // PLL, direct reference or link receiver feeding the sensor
    src_on = link.clk_run && (q.pll_run || bypass
      || q.regs[sensor_pkg::I_LINK_CLK][sensor_pkg::LINK_CLK_BIT]);
    if (q.pll_run && !q.locked) begin
      n.lock_cnt = q.lock_cnt + 16'h0001;
      if (q.lock_cnt == 16'(LOCK_CYC - 1)) begin
        n.locked = 1'b1;
      end
    end
    for (int i = 0; i < sensor_pkg::NREG; i++) begin
      if (link.addr == sensor_pkg::REG_ADDR[i]) begin
        hit = 1'b1;
        hi = i;
      end
    end
    // In low power standby only clock set-up registers respond
    ok = hit && (q.st != sensor_pkg::ST_LP_STBY || sensor_pkg::CM_SUBSET[hi]);
    if (link.req && !q.ack) begin
      n.ack = 1'b1;
      n.rdata = sensor_pkg::ZERO16;
      if (link.addr == sensor_pkg::A_LOCK_STAT && !link.we) begin
        n.rdata = {15'h0000, q.locked};
      end else if (!ok) begin
        n.err = 1'b1;
      end else if (link.we) begin
        n.regs[hi] = link.wdata;
        if (hi == sensor_pkg::I_PLL_EN) begin
          // PLL starts only once its soft reset is already released
          if (link.wdata == sensor_pkg::PLL_ON
              && q.regs[sensor_pkg::I_PLL_RST] == sensor_pkg::ZERO16) begin
            n.pll_run = 1'b1;
          end else begin
            n.pll_run = 1'b0;
            n.locked = 1'b0;
            n.lock_cnt = 16'h0000;
          end
        end
      end else begin
        n.rdata = q.regs[hi];
      end
    end
    // ------------------------------------------------------------
    // Power state ladder
    // ------------------------------------------------------------
    n.st = sensor_pkg::ST_LP_STBY;
    if (src_on) begin
      n.st = sensor_pkg::ST_STBY1;
      if ((!q.pll_run || q.locked)
          && q.regs[sensor_pkg::I_CGEN_RST] == sensor_pkg::ZERO16
          && q.regs[sensor_pkg::I_CLK_MGT][sensor_pkg::LOGIC_CLK_BIT]) begin
        n.st = sensor_pkg::ST_STBY2;
        if (q.regs[sensor_pkg::I_LOGIC_EN][sensor_pkg::LOGIC_EN_BIT]) begin
          n.st = sensor_pkg::ST_IDLE;
          if (q.regs[sensor_pkg::I_SEQ][sensor_pkg::SEQ_EN_BIT]) begin
            n.st = sensor_pkg::ST_RUN;
          end
        end
      end
    end
    n.lclk = n.st == sensor_pkg::ST_STBY2 || n.st == sensor_pkg::ST_IDLE
      || n.st == sensor_pkg::ST_RUN;
    n.blk = n.st == sensor_pkg::ST_IDLE || n.st == sensor_pkg::ST_RUN;
    n.grab = n.st == sensor_pkg::ST_RUN;
    n.shut = n.grab ? q.regs[sensor_pkg::I_SEQ][4:1] : 4'h0;
    // 0 none, 1 PLL, 2 link clock, 3 reference used directly
    n.src = !src_on ? 2'h0 : q.pll_run ? 2'h1 : bypass ? 2'h3 : 2'h2;
    // Clock loss stops the PLL but keeps register contents
    if (!link.clk_run) begin
      n.pll_run = 1'b0;
      n.locked = 1'b0;
      n.lock_cnt = 16'h0000;
    end
    if (!link.chip_rst_n) begin
      n = '0;
      n.regs = sensor_pkg::REG_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.regs <= sensor_pkg::REG_RESET;
    end else begin
      q <= n;
    end
  end

  assign link.ack = q.ack;
  assign link.err = q.err;
  assign link.rdata = q.rdata;
  assign dev_state = q.st;
  assign pll_locked = q.locked;
  assign logic_clk_on = q.lclk;
  assign blocks_on = q.blk;
  assign grabbing = q.grab;
  assign shutter_cfg = q.shut;
  assign sensor_clk_src = q.src;
endmodule : sensor_clock_dev

// *** src/sensor_bringup_host.sv ***
// Bring-up host: power-up timing and clock management uploads
`timescale 1ns/1ps
// Contract
// - standby two: logic clock, all registers open
// - idle: all blocks on except sequencer
// - running grabs in configured shutter mode
// - clock after supplies, reset after clock
// - wait 10 us after reset release
// - bring-up clock is PLL ref or link
// - phase one list chosen by mode, ordered
// - link clock runs in non-PLL serial modes
// - parallel mode bypasses PLL, uses reference
// - PLL lock flag polled before phase two
// - no lock poll for parallel or non-PLL
// - first write address 2 colour selection
// - 8-bit PLL phase one values
// - 10-bit PLL phase one values
// - 8-bit no-PLL: 32=0x2008, 20=0x0001
// - 10-bit no-PLL: 32=0x2000, 20=0x0001
// - parallel: 32, 20, then 16=0x0007
// - release PLL reset before enabling PLL
// - phase two: 9, then 32, then 34
// - logic clock value depends on mode
// - phase two strictly in order
// - low power standby: clock registers only
// - standby one: source clock, no logic clock
module sensor_bringup_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_ok,
  sensor_link_if.host link
);
  typedef enum logic [3:0] {
    H_IDLE, H_SUPPLY, H_SETTLE, H_RSTWAIT, H_P1, H_POLL, H_P2, H_DONE
  } hstate_t;

  typedef struct packed {
    logic last;
    logic [8:0] addr;
    logic [15:0] data;
  } upl_t;

  typedef struct packed {
    hstate_t st;
    sensor_pkg::out_mode_t mode;
    logic colour;
    logic [9:0] cnt;
    logic [3:0] idx;
    logic sup_s1;
    logic sup_s2;
    logic clk_run;
    logic rst_n;
    logic req;
    logic we;
    logic [8:0] addr;
    logic [15:0] wdata;
    logic done;
    logic err;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } hst_t;

  hst_t q;
  hst_t n;
  upl_t u;
  logic wr_take;
  logic pll_mode;

  // ------------------------------------------------------------
  // Upload tables
  // ------------------------------------------------------------
  function automatic upl_t p1_entry(input sensor_pkg::out_mode_t m, input logic col,
                                    input logic [3:0] i);
    upl_t e;
    logic s8;
    e = '{last: 1'b0, addr: sensor_pkg::A_COLOUR, data: {15'h0000, col}};
    s8 = m == sensor_pkg::M_S8_PLL;
    if (i == 4'h0) begin
      if (m == sensor_pkg::M_PAR10) begin
        e.data = sensor_pkg::PAR_SEL | {15'h0000, col};
      end
    end else if (m == sensor_pkg::M_S8_PLL || m == sensor_pkg::M_S10_PLL) begin
      case (i)
        4'h1: e = '{1'b0, sensor_pkg::A_CLK_MGT, s8 ? sensor_pkg::CM1_S8_PLL
                                                  : sensor_pkg::CM1_S10_PLL};
        4'h2: e = '{1'b0, sensor_pkg::A_LINK_CLK, sensor_pkg::ZERO16};
        4'h3: e = '{1'b0, sensor_pkg::A_PLL_CFG, s8 ? sensor_pkg::PLLC_S8
                                                 : sensor_pkg::PLLC_S10};
        4'h4: e = '{1'b0, sensor_pkg::A_LOCK_A, s8 ? sensor_pkg::LDA_S8
                                                : sensor_pkg::LDA_S10};
        4'h5: e = '{1'b0, sensor_pkg::A_LOCK_B, s8 ? sensor_pkg::LDB_S8
                                                : sensor_pkg::LDB_S10};
        4'h6: e = '{1'b0, sensor_pkg::A_PLL_RST, sensor_pkg::ZERO16};
        default: e = '{1'b1, sensor_pkg::A_PLL_EN, sensor_pkg::PLL_ON};
      endcase
    end else if (m == sensor_pkg::M_PAR10) begin
      case (i)
        4'h1: e = '{1'b0, sensor_pkg::A_CLK_MGT, sensor_pkg::CM1_PAR};
        4'h2: e = '{1'b0, sensor_pkg::A_LINK_CLK, sensor_pkg::ZERO16};
        default: e = '{1'b1, sensor_pkg::A_PLL_EN, sensor_pkg::PLL_BYPASS};
      endcase
    end else begin
      case (i)
        4'h1: e = '{1'b0, sensor_pkg::A_CLK_MGT, m == sensor_pkg::M_S8_NOPLL
              ? sensor_pkg::CM1_S8_NOPLL : sensor_pkg::CM1_S10_NOPLL};
        default: e = '{1'b1, sensor_pkg::A_LINK_CLK, sensor_pkg::ONE16};
      endcase
    end
    return e;
  endfunction : p1_entry

  function automatic upl_t p2_entry(input sensor_pkg::out_mode_t m, input logic [3:0] i);
    upl_t e;
    logic [15:0] v;
    case (m)
      sensor_pkg::M_S8_PLL: v = sensor_pkg::CM2_S8_PLL;
      sensor_pkg::M_S8_NOPLL: v = sensor_pkg::CM2_S8_NOPLL;
      sensor_pkg::M_S10_PLL: v = sensor_pkg::CM2_S10_PLL;
      sensor_pkg::M_S10_NOPLL: v = sensor_pkg::CM2_S10_NOPLL;
      default: v = sensor_pkg::CM2_PAR;
    endcase
    case (i)
      4'h0: e = '{1'b0, sensor_pkg::A_CGEN_RST, sensor_pkg::ZERO16};
      4'h1: e = '{1'b0, sensor_pkg::A_CLK_MGT, v};
      default: e = '{1'b1, sensor_pkg::A_LOGIC_EN, sensor_pkg::ONE16};
    endcase
    return e;
  endfunction : p2_entry

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    n.sup_s1 = supply_ok;
    n.sup_s2 = q.sup_s1;
    pll_mode = q.mode == sensor_pkg::M_S8_PLL || q.mode == sensor_pkg::M_S10_PLL;
    u = q.st == H_P2 ? p2_entry(q.mode, q.idx) : p1_entry(q.mode, q.colour, q.idx);
    wr_take = psel && penable && q.pready && pwrite && paddr == sensor_pkg::CTRL_OFS;
    // APB slave: one wait state, then pready for a single cycle
    n.pready = psel && penable && !q.pready;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (psel && penable && !q.pready) begin
      if (paddr == sensor_pkg::CTRL_OFS) begin
        n.prdata = {27'h0000000, q.colour, q.mode, 1'b0};
      end else if (paddr == sensor_pkg::STATUS_OFS) begin
        n.prdata = {25'h0000000, q.st != H_IDLE && q.st != H_DONE, q.err, q.done, q.st};
      end else begin
        n.pslverr = 1'b1;
      end
    end
    case (q.st)
      H_IDLE, H_DONE: begin
        if (wr_take && pwdata[sensor_pkg::C_START]) begin
          n.done = 1'b0;
          n.err = 1'b0;
          n.colour = pwdata[sensor_pkg::C_COLOUR];
          n.mode = sensor_pkg::out_mode_t'(pwdata[sensor_pkg::C_MODE_LSB +: 3]);
          if (pwdata[sensor_pkg::C_MODE_LSB +: 3] > 3'h4) begin
            n.err = 1'b1;
          end else begin
            n.st = H_SUPPLY;
            n.clk_run = 1'b0;
            n.rst_n = 1'b0;
          end
        end
      end
      H_SUPPLY: begin
        if (q.sup_s2) begin
          n.clk_run = 1'b1;
          n.cnt = 10'h000;
          n.st = H_SETTLE;
        end
      end
      H_SETTLE: begin
        n.cnt = q.cnt + 10'h001;
        if (q.cnt == 10'(sensor_pkg::CLK_SETTLE_CYC - 1)) begin
          n.rst_n = 1'b1;
          n.cnt = 10'h000;
          n.st = H_RSTWAIT;
        end
      end
      H_RSTWAIT: begin
        n.cnt = q.cnt + 10'h001;
        if (q.cnt == 10'(sensor_pkg::RST_WAIT_CYC - 1)) begin
          n.idx = 4'h0;
          n.st = H_P1;
        end
      end
      H_P1, H_POLL, H_P2: begin
        if (q.req) begin
          if (link.ack) begin
            n.req = 1'b0;
            if (link.err) begin
              n.err = 1'b1;
              n.st = H_IDLE;
            end else if (q.st == H_POLL) begin
              if (link.rdata[sensor_pkg::LOCK_BIT]) begin
                n.idx = 4'h0;
                n.st = H_P2;
              end
            end else if (!u.last) begin
              n.idx = q.idx + 4'h1;
            end else if (q.st == H_P2) begin
              n.done = 1'b1;
              n.st = H_DONE;
            end else begin
              n.idx = 4'h0;
              n.st = pll_mode ? H_POLL : H_P2;
            end
          end
        end else begin
          n.req = 1'b1;
          n.we = q.st != H_POLL;
          n.addr = q.st == H_POLL ? sensor_pkg::A_LOCK_STAT : u.addr;
          n.wdata = q.st == H_POLL ? sensor_pkg::ZERO16 : u.data;
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign link.clk_run = q.clk_run;
  assign link.chip_rst_n = q.rst_n;
  assign link.req = q.req;
  assign link.we = q.we;
  assign link.addr = q.addr;
  assign link.wdata = q.wdata;
endmodule : sensor_bringup_host

// *** dv/sensor_bringup_clock_sequencer_assertions.sv ***
// Link protocol and upload order checker for the bring-up pair
`timescale 1ns/1ps
module sensor_bringup_clock_sequencer_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_run,
  input wire logic chip_rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [8:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Upload history, cleared by chip reset
  // ------------------------------------------------------------
  logic [10:0] since_r;
  logic first_r, rel8_r, pll_r, byp_r, f9_r, f32_r, lock_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_r <= 11'h000;
      {first_r, rel8_r, pll_r, byp_r, f9_r, f32_r, lock_r} <= 7'h00;
    end else if (!chip_rst_n) begin
      since_r <= 11'h000;
      {first_r, rel8_r, pll_r, byp_r, f9_r, f32_r, lock_r} <= 7'h00;
    end else begin
      if (since_r != 11'h7FF) since_r <= since_r + 11'h001;
      if (ack && req && we) begin
        first_r <= 1'b1;
        if (addr == 9'h008 && wdata == 16'h0000) rel8_r <= 1'b1;
        if (addr == 9'h010) pll_r <= (wdata == 16'h0003);
        if (addr == 9'h010) byp_r <= (wdata == 16'h0007);
        if (addr == 9'h009) f9_r <= 1'b1;
        if (addr == 9'h020 && f9_r) f32_r <= 1'b1;
      end
      if (ack && req && !we && addr == 9'h018 && rdata[0]) lock_r <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_reset_after_clock: assert property ($rose(chip_rst_n) |-> clk_run && $past(clk_run, 8))
    else $error("chip reset released before clock settled");
  a_req_clocked: assert property (req |-> clk_run && chip_rst_n)
    else $error("request without running clock");
  a_wait_after_reset: assert property (req |-> since_r >= 11'h3E8)
    else $error("upload started too soon after reset");
  a_first_colour: assert property (req && we && !first_r |-> addr == 9'h002)
    else $error("first upload not to colour select");
  a_ack_pulse: assert property ($rose(req) |=> ack ##1 !ack)
    else $error("ack not a single pulse one cycle after request");
  a_req_held: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("request changed before ack");
  a_req_release: assert property (ack |=> !req)
    else $error("request kept after ack");
  a_no_refusal: assert property (ack |-> !err)
    else $error("device refused an upload");
  a_pll_after_rst: assert property (req && we && addr == 9'h010 && wdata == 16'h0003 |-> rel8_r)
    else $error("PLL enabled before soft reset release");
  a_lock_before_p2: assert property (req && we && addr == 9'h009 && pll_r |-> lock_r)
    else $error("phase two before lock seen");
  a_poll_only_pll: assert property (req && !we && addr == 9'h018 |-> pll_r && !byp_r)
    else $error("lock polled without PLL");
  a_phase_two_order: assert property (req && we && addr == 9'h022 |-> f9_r && f32_r)
    else $error("logic blocks enabled out of order");
  cover property (ack && req && !we && rdata[0]);
  cover property (ack && req && we && addr == 9'h022);
  cover property ($rose(chip_rst_n));
endmodule : sensor_bringup_clock_sequencer_assertions

// *** dv/sensor_bringup_clock_sequencer_test.sv ***
// Self-checking bench for the bring-up host and sensor device pair
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module sensor_bringup_clock_sequencer_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic supply_ok = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, pll_locked, logic_clk_on, blocks_on, grabbing;
  logic [2:0] dev_state;
  logic [3:0] shutter_cfg;
  logic [1:0] sensor_clk_src;
  int n_fail = 0;
  int tests_run = 0;
  int n_poll, n;
  logic [24:0] exp_q[$];
  logic [24:0] got_q[$];
  logic [15:0] cm1 [5] = '{16'h200C, 16'h2008, 16'h2004, 16'h2000, 16'h200C};
  logic [15:0] cm2 [5] = '{16'h200E, 16'h200A, 16'h2006, 16'h2002, 16'h200E};
  logic [1:0] src [5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h3};
  sensor_link_if lnk();
  always #5 pclk = ~pclk;
  sensor_bringup_host sensor_bringup_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok), .link(lnk));
  sensor_clock_dev #(.LOCK_CYC(4)) sensor_clock_dev_inst (.pclk(pclk), .presetn(presetn),
    .link(lnk), .dev_state(dev_state), .pll_locked(pll_locked), .logic_clk_on(logic_clk_on),
    .blocks_on(blocks_on), .grabbing(grabbing), .shutter_cfg(shutter_cfg),
    .sensor_clk_src(sensor_clk_src));
  sensor_bringup_clock_sequencer_assertions sensor_bringup_clock_sequencer_assertions_inst (
    .pclk(pclk), .presetn(presetn), .clk_run(lnk.clk_run), .chip_rst_n(lnk.chip_rst_n),
    .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
    .err(lnk.err), .rdata(lnk.rdata));
  // ------------------------------------------------------------
  // Link monitor
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    if (lnk.ack && lnk.req && lnk.we) got_q.push_back({lnk.addr, lnk.wdata});
    if (lnk.ack && lnk.req && !lnk.we && lnk.addr == 9'h018) n_poll++;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Entered just after an edge; waits are bounded so a dead slave ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) begin
      n_fail++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic push(input logic [8:0] a, input logic [15:0] d);
    exp_q.push_back({a, d});
  endtask : push
  task automatic build(input int m, input logic c);
    exp_q = {};
    push(9'h002, {14'h0, m == 4, c});
    push(9'h020, cm1[m]);
    push(9'h014, {15'h0, m == 1 || m == 3});
    if (m == 0 || m == 2) begin
      push(9'h011, (m == 0) ? 16'h210F : 16'h2113);
      push(9'h01A, (m == 0) ? 16'h1180 : 16'h2280);
      push(9'h01B, (m == 0) ? 16'hCCBC : 16'h3D2D);
      push(9'h008, 16'h0000);
      push(9'h010, 16'h0003);
    end
    if (m == 4) push(9'h010, 16'h0007);
    push(9'h009, 16'h0000);
    push(9'h020, cm2[m]);
    push(9'h022, 16'h0001);
  endtask : build
  // Resets between runs also exercise the checker across reset
  task automatic reset_dut();
    presetn <= 1'b0;
    supply_ok <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : reset_dut
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset_dut();
    apb(1'b0, 12'h000, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b0, 12'h008, 32'h0);
    `CHK({e, q}, 33'h100000000)
    apb(1'b1, 12'h000, 32'h0000000B);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(q[5], 1'b1)
    for (int m = 0; m < 5; m++) begin
      reset_dut();
      build(m, m[0]);
      got_q = {};
      n_poll = 0;
      supply_ok <= (m != 0);
      apb(1'b1, 12'h000, {27'h0, m[0], m[2:0], 1'b1});
      if (m == 0) begin
        repeat (40) @(posedge pclk);
        `CHK(lnk.clk_run, 1'b0)
        supply_ok <= 1'b1;
      end
      apb(1'b0, 12'h000, 32'h0);
      `CHK(q[4:1], {m[0], m[2:0]})
      n = 0;
      do begin
        apb(1'b0, 12'h004, 32'h0);
        n++;
      end while (q[4] !== 1'b1 && n < 1000);
      if (n == 1000) n_fail++;
      if (n == 1000) complete_run();
      `CHK(q[6:4], 3'h1)
      `CHK(got_q.size(), exp_q.size())
      foreach (exp_q[i]) `CHK(got_q[i], exp_q[i])
      `CHK(n_poll > 0, m == 0 || m == 2)
      `CHK(sensor_clk_src, src[m])
      `CHK(pll_locked, 1'(m == 0 || m == 2))
      `CHK({dev_state, logic_clk_on, blocks_on, grabbing, shutter_cfg}, 10'h1E0)
    end
    complete_run();
  end
endmodule : sensor_bringup_clock_sequencer_test
